// ### core/seepc_defs.svh
`ifndef SEEPC_DEFS_SVH
`define SEEPC_DEFS_SVH

// Opcodes
`define SEEPC_OP_SET_LATCH 8'h06
`define SEEPC_OP_CLR_LATCH 8'h04
`define SEEPC_OP_STAT_RD 8'h05
`define SEEPC_OP_STAT_WR 8'h01
`define SEEPC_OP_ARR_RD 8'h03
`define SEEPC_OP_ARR_WR 8'h02

// Status byte field positions
`define SEEPC_SB_LOCK 7
`define SEEPC_SB_AREA_HI 3
`define SEEPC_SB_AREA_LO 2
`define SEEPC_SB_LATCH 1
`define SEEPC_SB_BUSY 0

// Bit counts
`define SEEPC_BYTE_BITS 8
`define SEEPC_ADDR_BITS 16

// Self-timed cycle, in us, and its cycle count at 100 MHz
`define SEEPC_WRITE_TIME_US 5
`define SEEPC_CLK_MHZ 100
`define SEEPC_WRITE_CYCLES (`SEEPC_WRITE_TIME_US * `SEEPC_CLK_MHZ)

`endif

// ### core/seepc_pkg.sv
`default_nettype none
package seepc_pkg;
  // Phases of one selected transfer
  typedef enum logic [2:0] {
    SEEPC_OPCODE,
    SEEPC_WAIT_HIGH,
    SEEPC_STAT_OUT,
    SEEPC_STAT_DATA,
    SEEPC_ADDR,
    SEEPC_DATA,
    SEEPC_IGNORE
  } seepc_phase_t;

  typedef enum logic [1:0] {
    SEEPC_CMD_NONE,
    SEEPC_CMD_SET,
    SEEPC_CMD_CLR
  } seepc_latch_cmd_t;
endpackage
`default_nettype wire

// ### core/seepc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser; first stage is read by the second only
module seepc_sync (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rst_val,
  input wire logic async_in,
  output logic sync_out
);
  logic meta;

  // Reset value chosen by the instantiation, a constant there
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta <= rst_val;
      sync_out <= rst_val;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// ### core/seepc_core.sv
// Contract
// R1: Opcodes 06h set latch, 04h clear latch, 05h read status.
// R2: Opcodes 01h status write, 03h array read, 02h array write.
// R3: Unknown opcode deselects; rest ignored until chip select rises.
// R4: Latch must be set before writes; only set-latch sets it.
// R5: Set-latch takes effect when chip select goes high.
// R6: Clear-latch takes effect when chip select goes high.
// R7: Latch clears at reset, clear-latch, status and array write completion.
// R8: Status read accepted anytime; status byte repeats while clocks continue.
// R9: Master should poll busy flag before new instructions during writes.
// R10: Busy flag is 1 during a write cycle, else 0.
// R11: Array and status writes rejected while latch is 0.
// R12: Block-protect bits set only by status write; nonzero protects region.
// R13: Lock 1 with guard low gives hardware mode; status writes refused.
// R14: Status write ignores data bits 6, 5, 4, 1, 0.
// R15: Status bits 6, 5, 4 always read 0.
// R16: Chip select must rise right after eighth data bit, else discarded.
// R17: Valid status write starts fixed busy cycle; latch clears at end.
// R18: Old protection values stay in force until the cycle completes.
// R19: Lock 0: status write accepted when latch set, any guard level.
// R20: Lock 1: status write accepted only with guard high.
// R21: Hardware mode entered in either order; left when guard goes high.
// R22: Upper address bits beyond the variant's size are ignored.
// R23: Protect field 00 none, 01 upper quarter, 10 half, 11 all.
// R24: Writes accepted only if clock count is a multiple of eight.
// R25: Status byte: lock b7, protect b3:b2, latch b1, busy b0.
// R26: Decoding restarts at chip select fall; counter clears while high.
`timescale 1ns/1ps
`default_nettype none
`include "seepc_defs.svh"
module seepc_core #(
  parameter int WRITE_CYCLES = `SEEPC_WRITE_CYCLES,
  parameter int ADDR_WIDTH = 13,
  parameter logic [1:0] PROT_RESET = 2'b00,
  parameter logic LOCK_RESET = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spi_clk,
  input wire logic spi_sel_n,
  input wire logic spi_din,
  input wire logic guard_n,
  output logic spi_dout,
  output logic spi_dout_oe,
  output logic write_cycle_busy,
  output logic write_latch_flag,
  output logic status_lock_flag,
  output logic [1:0] area_guard,
  output logic soft_guard_mode,
  output logic hard_guard_mode,
  output logic arr_rd_start,
  output logic [ADDR_WIDTH-1:0] arr_addr,
  output logic arr_wr_byte_valid,
  output logic [7:0] arr_wr_byte,
  output logic arr_wr_commit,
  output logic arr_wr_refused
);
  import seepc_pkg::*;

  localparam logic [15:0] ADDR_MASK = 16'((1 << ADDR_WIDTH) - 1);
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

  logic clk_s, sel_n_s, din_s, guard_n_s;
  logic clk_d, sel_d;
  logic clk_rise, clk_fall, sel_fall, sel_rise;
  seepc_phase_t phase;
  logic [7:0] shreg;
  logic [2:0] bit_cnt;
  logic [3:0] byte_cnt;
  logic [15:0] addr_sh;
  logic [7:0] stat_sh;
  logic [7:0] pend_stat;
  logic arr_wr_ok;
  logic stat_wr_ok;
  logic [CNT_W-1:0] busy_cnt;
  logic busy_stat;
  logic [7:0] status_byte;
  logic [7:0] next_byte;
  logic [ADDR_WIDTH-1:0] masked_addr;
  logic addr_prot;
  logic stat_wr_allow;
  logic done_pulse;

  // Pins from the master and the guard pin cross into clk_sys here
  seepc_sync u_sync_clk (.clk_sys(clk_sys), .rst(rst), .rst_val(1'b0),
    .async_in(spi_clk), .sync_out(clk_s));
  seepc_sync u_sync_sel (.clk_sys(clk_sys), .rst(rst), .rst_val(1'b1),
    .async_in(spi_sel_n), .sync_out(sel_n_s));
  seepc_sync u_sync_din (.clk_sys(clk_sys), .rst(rst), .rst_val(1'b0),
    .async_in(spi_din), .sync_out(din_s));
  seepc_sync u_sync_grd (.clk_sys(clk_sys), .rst(rst), .rst_val(1'b1),
    .async_in(guard_n), .sync_out(guard_n_s));

  // Edge detection on synchronised copies; sel_d starts high so a
  // fall must be seen before the first selection
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clk_d <= 1'b0;
      sel_d <= 1'b1;
    end else begin
      clk_d <= clk_s;
      sel_d <= sel_n_s;
    end
  end
  assign clk_rise = clk_s & ~clk_d & ~sel_n_s;
  assign clk_fall = ~clk_s & clk_d & ~sel_n_s;
  assign sel_fall = ~sel_n_s & sel_d;
  assign sel_rise = sel_n_s & ~sel_d;

  // Status byte with unused bits tied low
  always_comb begin
    status_byte = 8'h00; // see R15
    status_byte[`SEEPC_SB_LOCK] = status_lock_flag; // see R25
    status_byte[`SEEPC_SB_AREA_HI] = area_guard[1];
    status_byte[`SEEPC_SB_AREA_LO] = area_guard[0];
    status_byte[`SEEPC_SB_LATCH] = write_latch_flag;
    status_byte[`SEEPC_SB_BUSY] = write_cycle_busy;
  end

  // Protection modes; hard mode is purely combinational on the
  // current lock and guard, so the order of setting does not matter
  assign hard_guard_mode = status_lock_flag & ~guard_n_s; // see R13, R21
  assign soft_guard_mode = ~hard_guard_mode & (area_guard != 2'b00);
  assign stat_wr_allow = write_latch_flag & ~write_cycle_busy &
    (~status_lock_flag | guard_n_s); // see R11, R19, R20

  // Address decode ignores bits above the variant's range
  assign masked_addr = ADDR_WIDTH'(addr_sh & ADDR_MASK); // see R22
  always_comb begin
    case (area_guard) // see R23, R12
      2'b01: addr_prot = masked_addr[ADDR_WIDTH-1 -: 2] == 2'b11;
      2'b10: addr_prot = masked_addr[ADDR_WIDTH-1];
      2'b11: addr_prot = 1'b1;
      default: addr_prot = 1'b0;
    endcase
  end

  // Byte just completed on this rising edge
  assign next_byte = {shreg[6:0], din_s};

  // Transfer sequencing, one phase per field of the instruction
  always_ff @(posedge clk_sys) begin
    if (rst || sel_n_s) begin
      phase <= SEEPC_OPCODE; // see R26
      bit_cnt <= 3'd0;
      byte_cnt <= 4'd0;
    end else if (clk_rise) begin
      bit_cnt <= bit_cnt + 3'd1;
      if (bit_cnt == 3'd7) begin
        if (byte_cnt != 4'hf)
          byte_cnt <= byte_cnt + 4'd1;
        case (phase)
          SEEPC_OPCODE: begin
            case (next_byte) // see R1, R2
              `SEEPC_OP_SET_LATCH: phase <= SEEPC_WAIT_HIGH;
              `SEEPC_OP_CLR_LATCH: phase <= SEEPC_WAIT_HIGH;
              `SEEPC_OP_STAT_RD: phase <= SEEPC_STAT_OUT; // see R8
              `SEEPC_OP_STAT_WR: phase <= SEEPC_STAT_DATA;
              `SEEPC_OP_ARR_RD: phase <= SEEPC_ADDR;
              `SEEPC_OP_ARR_WR: phase <= SEEPC_ADDR;
              default: phase <= SEEPC_IGNORE; // see R3
            endcase
          end
          SEEPC_STAT_DATA: phase <= SEEPC_IGNORE; // see R16
          SEEPC_ADDR: begin
            if (byte_cnt == 4'd2)
              phase <= SEEPC_DATA;
          end
          default: phase <= phase;
        endcase
      end
    end
  end

  // Shift register and captured opcode context
  logic [7:0] opcode;
  always_ff @(posedge clk_sys) begin
    if (rst || sel_n_s) begin
      shreg <= 8'h00;
    end else if (clk_rise) begin
      shreg <= next_byte;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      opcode <= 8'h00;
    end else if (sel_fall) begin
      opcode <= 8'h00;
    end else if (clk_rise && phase == SEEPC_OPCODE && bit_cnt == 3'd7) begin
      opcode <= next_byte;
    end
  end

  // Address bytes, shifted in for both array commands
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_sh <= 16'h0000;
    end else if (clk_rise && phase == SEEPC_ADDR) begin
      addr_sh <= {addr_sh[14:0], din_s};
    end
  end
  assign arr_addr = masked_addr;

  // Array-side strobes to the storage sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      arr_rd_start <= 1'b0;
      arr_wr_byte_valid <= 1'b0;
      arr_wr_byte <= 8'h00;
    end else begin
      arr_rd_start <= clk_rise && bit_cnt == 3'd7 && phase == SEEPC_ADDR &&
        byte_cnt == 4'd2 && opcode == `SEEPC_OP_ARR_RD && !write_cycle_busy;
      arr_wr_byte_valid <= clk_rise && bit_cnt == 3'd7 &&
        phase == SEEPC_DATA && opcode == `SEEPC_OP_ARR_WR;
      if (clk_rise && bit_cnt == 3'd7 && phase == SEEPC_DATA)
        arr_wr_byte <= next_byte;
    end
  end

  // Acceptance at chip select rise; the bit count must be on a byte
  // boundary and the write must still be allowed at that rise
  assign arr_wr_ok = opcode == `SEEPC_OP_ARR_WR && phase == SEEPC_DATA &&
    bit_cnt == 3'd0 && byte_cnt > 4'd3 && write_latch_flag &&
    !write_cycle_busy && !addr_prot; // see R11, R24
  assign stat_wr_ok = opcode == `SEEPC_OP_STAT_WR && stat_wr_allow &&
    bit_cnt == 3'd0 && byte_cnt == 4'd2; // see R16, R24

  // Status data byte; only lock and protect bits are taken
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_sh <= 8'h00;
    end else if (clk_rise && phase == SEEPC_STAT_DATA && bit_cnt == 3'd7) begin
      stat_sh <= next_byte;
    end
  end

  // Self-timed cycle; pend_stat holds new values until completion
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_cnt <= '0;
      write_cycle_busy <= 1'b0;
      busy_stat <= 1'b0;
      pend_stat <= 8'h00;
      arr_wr_commit <= 1'b0;
      arr_wr_refused <= 1'b0;
    end else begin
      arr_wr_commit <= 1'b0;
      arr_wr_refused <= 1'b0;
      if (sel_rise && (stat_wr_ok || arr_wr_ok)) begin
        write_cycle_busy <= 1'b1; // see R10, R17
        busy_cnt <= CNT_W'(WRITE_CYCLES - 1);
        busy_stat <= stat_wr_ok;
        pend_stat <= stat_sh;
        arr_wr_commit <= arr_wr_ok;
      end else if (write_cycle_busy) begin
        if (busy_cnt == '0)
          write_cycle_busy <= 1'b0;
        else
          busy_cnt <= busy_cnt - CNT_W'(1);
      end
      if (sel_rise && opcode == `SEEPC_OP_ARR_WR && !arr_wr_ok)
        arr_wr_refused <= 1'b1;
    end
  end
  assign done_pulse = write_cycle_busy && busy_cnt == '0;

  // Non-volatile protection bits, updated only at cycle end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_lock_flag <= LOCK_RESET;
      area_guard <= PROT_RESET;
    end else if (done_pulse && busy_stat) begin
      status_lock_flag <= pend_stat[`SEEPC_SB_LOCK]; // see R18, R14
      area_guard <= {pend_stat[`SEEPC_SB_AREA_HI],
        pend_stat[`SEEPC_SB_AREA_LO]}; // see R12
    end
  end

  // Write latch: set/clear executed at chip select rise
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      write_latch_flag <= 1'b0; // see R7
    end else if (done_pulse) begin
      write_latch_flag <= 1'b0; // see R7, R17
    end else if (sel_rise && phase == SEEPC_WAIT_HIGH && bit_cnt == 3'd0) begin
      if (opcode == `SEEPC_OP_SET_LATCH)
        write_latch_flag <= 1'b1; // see R4, R5
      else if (opcode == `SEEPC_OP_CLR_LATCH)
        write_latch_flag <= 1'b0; // see R6
    end
  end

  // Status byte shifted out on falling edges, repeating each byte
  logic [7:0] out_sh;
  always_ff @(posedge clk_sys) begin
    if (rst || sel_n_s) begin
      out_sh <= 8'h00;
      spi_dout <= 1'b0;
      spi_dout_oe <= 1'b0;
    end else if (clk_fall && phase == SEEPC_STAT_OUT) begin
      spi_dout_oe <= 1'b1;
      if (bit_cnt == 3'd0) begin
        spi_dout <= status_byte[7]; // see R8
        out_sh <= {status_byte[6:0], 1'b0};
      end else begin
        spi_dout <= out_sh[7];
        out_sh <= {out_sh[6:0], 1'b0};
      end
    end else if (phase == SEEPC_IGNORE) begin
      spi_dout_oe <= 1'b0; // see R3
    end
  end
endmodule
`default_nettype wire

// ### tb/seepc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module seepc_chk #(
  parameter int WRITE_CYCLES = 500
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic guard_n,
  input wire logic spi_sel_n,
  input wire logic spi_dout_oe,
  input wire logic write_cycle_busy,
  input wire logic write_latch_flag,
  input wire logic status_lock_flag,
  input wire logic [1:0] area_guard,
  input wire logic soft_guard_mode,
  input wire logic hard_guard_mode,
  input wire logic arr_wr_commit,
  input wire logic arr_wr_refused
);
  int busy_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Length of the running busy stretch, read when it ends
  always_ff @(posedge clk_sys) begin
    if (rst || !write_cycle_busy) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  property p_busy_len;
    $fell(write_cycle_busy) |-> busy_cnt == WRITE_CYCLES;
  endproperty
  property p_lat_end;
    $fell(write_cycle_busy) |-> !write_latch_flag;
  endproperty
  // Checked where the cycle starts; a clear-latch later is still legal
  property p_lat_busy;
    $rose(write_cycle_busy) |-> write_latch_flag;
  endproperty
  // Output driver lets go within a few cycles of deselection
  property p_oe_off;
    spi_sel_n [*4] |-> !spi_dout_oe;
  endproperty
  property p_frozen;
    write_cycle_busy && $past(write_cycle_busy)
      |-> $stable({status_lock_flag, area_guard});
  endproperty
  property p_hard_lock;
    hard_guard_mode |-> status_lock_flag && !soft_guard_mode;
  endproperty
  property p_soft;
    soft_guard_mode == (area_guard != 2'h0 && !hard_guard_mode);
  endproperty
  // Five cycles cover the pin synchroniser latency
  property p_hard_on;
    (status_lock_flag && !guard_n) [*5] |-> hard_guard_mode;
  endproperty
  property p_hard_off;
    guard_n [*5] |-> !hard_guard_mode;
  endproperty
  property p_commit;
    arr_wr_commit |-> ##[0:4] write_cycle_busy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy span");
  a_lat_end: assert property (p_lat_end) else $error("latch kept");
  a_lat_busy: assert property (p_lat_busy) else $error("no latch");
  a_frozen: assert property (p_frozen) else $error("bits moved");
  a_hard_lock: assert property (p_hard_lock) else $error("hard");
  a_soft: assert property (p_soft) else $error("soft mode");
  a_hard_on: assert property (p_hard_on) else $error("no hard");
  a_hard_off: assert property (p_hard_off) else $error("hard kept");
  a_commit: assert property (p_commit) else $error("no busy");
  a_oe_off: assert property (p_oe_off) else $error("dout on");
  c_busy: cover property ($rose(write_cycle_busy));
  c_hard: cover property ($rose(hard_guard_mode));
  c_refused: cover property (arr_wr_refused);
  c_stat_out: cover property ($rose(spi_dout_oe));
endmodule
bind seepc_core seepc_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .guard_n(guard_n),
  .spi_sel_n(spi_sel_n), .spi_dout_oe(spi_dout_oe),
  .write_cycle_busy(write_cycle_busy), .write_latch_flag(write_latch_flag),
  .status_lock_flag(status_lock_flag), .area_guard(area_guard),
  .soft_guard_mode(soft_guard_mode), .hard_guard_mode(hard_guard_mode),
  .arr_wr_commit(arr_wr_commit), .arr_wr_refused(arr_wr_refused)
);
`default_nettype wire

// ### tb/seepc_master.sv
`timescale 1ns/1ps
`default_nettype none
module seepc_master (
  input wire logic clk_sys,
  input wire logic spi_dout,
  output logic spi_clk,
  output logic spi_sel_n,
  output logic spi_din,
  output logic rd_stb,
  output logic [7:0] rd_byte
);
  // Idle: deselected, clock parked low between frames
  initial begin
    spi_clk = 1'b0;
    spi_sel_n = 1'b1;
    spi_din = 1'b0;
    rd_stb = 1'b0;
    rd_byte = 8'h00;
  end
  // Half of the 80 ns link period, just after a system edge
  task automatic half();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  // nb bits of tx MSB first, then nrd bytes sampled on rising edges
  task automatic frame(input logic [31:0] tx, input int nb, input int nrd);
    logic [7:0] sh;
    spi_sel_n = 1'b0;
    half();
    for (int i = 0; i < nb + 8 * nrd; i++) begin
      spi_din = (i < nb) ? tx[nb - 1 - i] : 1'($urandom);
      half();
      spi_clk = 1'b1;
      sh = {sh[6:0], spi_dout};
      if (i >= nb && (i - nb) % 8 == 7) begin
        rd_byte = sh;
        rd_stb = 1'b1;
      end
      half();
      spi_clk = 1'b0;
      rd_stb = 1'b0;
    end
    // Deselect inside the low phase after the last rise
    half();
    spi_sel_n = 1'b1;
    spi_din = ~spi_din;
    half();
    half();
  endtask
endmodule
`default_nettype wire

// ### tb/spi_eeprom_cmd_and_protection_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_cmd_and_protection_tb_top;
  localparam int WCYC = 400;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic guard_n = 1'b1;
  logic spi_clk, spi_sel_n, spi_din, spi_dout, rd_stb;
  logic write_cycle_busy, write_latch_flag, status_lock_flag;
  logic soft_guard_mode, hard_guard_mode, arr_wr_commit, arr_wr_refused;
  logic [1:0] area_guard;
  logic arr_rd_start, arr_wr_byte_valid;
  logic [7:0] arr_wr_byte;
  logic [7:0] by_q[$];
  logic [12:0] ad_q[$];
  logic [12:0] arr_addr;
  logic [7:0] rd_byte;
  logic [7:0] st_q[$];
  logic [13:0] wr_q[$];
  int n_mismatch = 0;
  int n_checks = 0;
  always #5 clk_sys = ~clk_sys;
  seepc_core #(.WRITE_CYCLES(WCYC)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .spi_clk(spi_clk),
    .spi_sel_n(spi_sel_n), .spi_din(spi_din), .guard_n(guard_n),
    .spi_dout(spi_dout), .spi_dout_oe(), .write_cycle_busy(write_cycle_busy),
    .write_latch_flag(write_latch_flag), .status_lock_flag(status_lock_flag),
    .area_guard(area_guard), .soft_guard_mode(soft_guard_mode),
    .hard_guard_mode(hard_guard_mode), .arr_rd_start(arr_rd_start),
    .arr_addr(arr_addr), .arr_wr_byte_valid(arr_wr_byte_valid),
    .arr_wr_byte(arr_wr_byte), .arr_wr_commit(arr_wr_commit),
    .arr_wr_refused(arr_wr_refused)
  );
  seepc_master u_mst (
    .clk_sys(clk_sys), .spi_dout(spi_dout), .spi_clk(spi_clk),
    .spi_sel_n(spi_sel_n), .spi_din(spi_din), .rd_stb(rd_stb),
    .rd_byte(rd_byte)
  );
  task automatic cmp_stat(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_addr(input logic [12:0] got, input logic [12:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_wr(input logic [13:0] got, input logic [13:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Each status byte read back meets the oldest expectation
  always @(posedge rd_stb) begin
    cmp_stat(rd_byte, st_q.pop_front());
  end
  // Array-side results, looked at mid-cycle where the pulses stand
  always @(negedge clk_sys) begin
    if (arr_wr_commit === 1'b1 || arr_wr_refused === 1'b1) begin
      cmp_wr({arr_wr_commit, arr_addr}, wr_q.pop_front());
    end
    if (arr_wr_byte_valid === 1'b1) begin
      cmp_byte(arr_wr_byte, by_q.pop_front());
    end
    if (arr_rd_start === 1'b1) begin
      cmp_addr(arr_addr, ad_q.pop_front());
    end
  end
  task automatic rd(input logic [7:0] exp, input int n);
    repeat (n) st_q.push_back(exp);
    u_mst.frame(32'h0000_0005, 8, n);
  endtask
  task automatic op(input logic [7:0] c);
    u_mst.frame({24'h00_0000, c}, 8, 0);
  endtask
  // Short counts keep the opening bits and drop the tail
  task automatic status_write_cmd(input logic [7:0] d, input int nb);
    u_mst.frame({16'h0000, 8'h01, d} >> (16 - nb), nb, 0);
  endtask
  task automatic awr(input logic [15:0] a, input logic [13:0] exp);
    logic [7:0] d;
    d = 8'($urandom);
    wr_q.push_back(exp);
    by_q.push_back(d);
    u_mst.frame({8'h02, a, d}, 32, 0);
  endtask
  task automatic ard(input logic [15:0] a, input logic [12:0] exp);
    ad_q.push_back(exp);
    u_mst.frame({8'h00, 8'h03, a}, 24, 0);
  endtask
  // Fixed wait: the self-timed cycle length is a set parameter
  task automatic settle();
    repeat (WCYC + 10) @(posedge clk_sys);
    #1;
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #200_000;
    n_mismatch++;
    final_report();
  end
  initial begin
    void'($urandom(14));
    repeat (16) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    rd(8'h00, 1);
    op(8'h06);
    rd(8'h02, 1);
    op(8'h04);
    rd(8'h00, 1);
    status_write_cmd(8'h8c, 16);
    rd(8'h00, 1);
    u_mst.frame(32'h0000_a506, 16, 0);
    rd(8'h00, 1);
    op(8'h06);
    status_write_cmd(8'h8c, 15);
    rd(8'h02, 1);
    status_write_cmd(8'hfc, 16);
    rd(8'h03, 1);
    settle();
    rd(8'h8c, 2);
    guard_n = 1'b0;
    op(8'h06);
    status_write_cmd(8'h00, 16);
    rd(8'h8e, 1);
    guard_n = 1'b1;
    status_write_cmd(8'h00, 16);
    settle();
    rd(8'h00, 1);
    guard_n = 1'b0;
    op(8'h06);
    status_write_cmd(8'h84, 16);
    settle();
    rd(8'h84, 1);
    op(8'h06);
    status_write_cmd(8'h00, 16);
    rd(8'h86, 1);
    guard_n = 1'b1;
    status_write_cmd(8'h04, 16);
    settle();
    op(8'h06);
    awr(16'hf800, {1'b0, 13'h1800});
    awr(16'he7ff, {1'b1, 13'h07ff});
    settle();
    rd(8'h04, 1);
    ard(16'hf234, 13'h1234);
    n_mismatch += st_q.size() + wr_q.size() + by_q.size() + ad_q.size();
    final_report();
  end
endmodule
`default_nettype wire
